// ---- pkg/cisg_pkg.sv ----
// constants for the per-interface interrupt request generation stage
package cisg_pkg;
    localparam int CISG_NUM_CPU = 8;             // most interfaces the type field can name
    localparam int CISG_NUM_INT = 32;            // interrupts searched per interface
    localparam int CISG_ID_W = 10;               // interrupt number width
    localparam logic [9:0] CISG_ID_NONE = 10'h3ff; // spurious / nothing pending
    localparam logic [7:0] CISG_PRIO_NONE = 8'hff; // priority seen for the spurious id
    localparam int CISG_CNT_LSB = 5;             // type field: interface count, low bit
    localparam int CISG_CNT_MSB = 7;             // type field: interface count, high bit
    localparam int CISG_MIN_BP = 0;              // smallest binary point implemented
    localparam logic [15:0] CISG_MASK_SEED = 16'hff00; // seed for the grouping mask
    localparam logic [7:0] CISG_RST_REQ = 8'h00; // request and wake lines after reset
    localparam logic [9:0] CISG_RST_ID = 10'h3ff; // best-id outputs after reset
endpackage : cisg_pkg

// ---- hw/cisg_top.sv ----
// request and wake-up generation for every processor interface
//
// Summary of operation
// R01 - evaluate each interface, count from type bits
// R02 - group0 fast: wake, request if iface enabled
// R03 - else normal wake, request if group enabled
// R04 - fast line follows legacy input when bypassed
// R05 - normal line follows legacy input when bypassed
// R06 - candidate: best, pending, beats priority mask
// R07 - group0 needs dist enable and preemption
// R08 - group1 needs dist enable and preemption
// R09 - grouping masks from binary point fields
// R10 - ungrouped: normal line only, both enables
// R11 - physical path unaffected by virtualization
// R12 - smaller priority value means higher priority
// R13 - nothing pending gives interrupt number 1023
// R14 - mask keeps top bits, ns decrement, saturate
// R15 - pending means set, not active, targeted, enabled
// R16 - outputs registered, clear forces requests low
`timescale 1ns/1ps
module cisg_top
    import cisg_pkg::*;
(
    input wire logic I_CORE_CLK,
    input wire logic I_ARST_N,
    input wire logic I_SYNC_CLR,
    input wire logic [7:0] I_CONTROLLER_TYPE_INFO,
    input wire logic I_GROUPING_EN,
    input wire logic I_BYPASS_EN,
    input wire logic I_DIST_GROUP_ZERO_ENABLE,
    input wire logic I_DIST_GROUP_ONE_ENABLE,
    input wire logic [CISG_NUM_INT-1:0] I_INT_PENDING,
    input wire logic [CISG_NUM_INT-1:0] I_INT_ACTIVE,
    input wire logic [CISG_NUM_INT-1:0] I_INT_ENABLED,
    input wire logic [CISG_NUM_INT-1:0] I_INT_GROUP_ZERO,
    input wire logic [CISG_NUM_INT*8-1:0] I_INTERRUPT_PRIORITY_TABLE,
    input wire logic [CISG_NUM_INT*CISG_NUM_CPU-1:0] I_INT_TARGET,
    input wire logic [CISG_NUM_CPU-1:0] I_ANY_ACTIVE,
    input wire logic [CISG_NUM_CPU-1:0] I_GROUP0_AS_FAST_SELECT,
    input wire logic [CISG_NUM_CPU-1:0] I_GROUP_ZERO_ENABLE,
    input wire logic [CISG_NUM_CPU-1:0] I_GROUP_ONE_ENABLE,
    input wire logic [CISG_NUM_CPU-1:0] I_FAST_BYPASS_DISABLE_G0,
    input wire logic [CISG_NUM_CPU-1:0] I_FAST_BYPASS_DISABLE_G1,
    input wire logic [CISG_NUM_CPU-1:0] I_NORMAL_BYPASS_DISABLE_G0,
    input wire logic [CISG_NUM_CPU-1:0] I_NORMAL_BYPASS_DISABLE_G1,
    input wire logic [CISG_NUM_CPU-1:0] I_COMMON_BINARY_POINT,
    input wire logic [CISG_NUM_CPU*3-1:0] I_BINARY_POINT,
    input wire logic [CISG_NUM_CPU*3-1:0] I_ALIASED_BINARY_POINT,
    input wire logic [CISG_NUM_CPU*8-1:0] I_PRIORITY_MASK,
    input wire logic [CISG_NUM_CPU*8-1:0] I_RUNNING_PRIORITY,
    input wire logic [CISG_NUM_CPU-1:0] I_LEGACY_FAST_INPUT,
    input wire logic [CISG_NUM_CPU-1:0] I_LEGACY_NORMAL_INPUT,
    output logic [CISG_NUM_CPU-1:0] O_FAST_REQ,
    output logic [CISG_NUM_CPU-1:0] O_NORMAL_REQ,
    output logic [CISG_NUM_CPU-1:0] O_FAST_WAKE,
    output logic [CISG_NUM_CPU-1:0] O_NORMAL_WAKE,
    output logic [CISG_NUM_CPU*CISG_ID_W-1:0] O_BEST_ID
);

    // grouping mask for binary point n, ns selects the decrement
    function automatic logic [7:0] grp_mask(input logic [2:0] bp, input logic ns);
        int n;
        logic [15:0] sh;
        n = int'(bp);
        if (ns) begin
            n = n - 1; // [R14]
        end
        if (n < CISG_MIN_BP) begin
            n = CISG_MIN_BP; // [R14]
        end
        sh = CISG_MASK_SEED >> (7 - n);
        return sh[7:0]; // [R14]
    endfunction

    logic [CISG_NUM_CPU-1:0] fast_meta_r; // legacy fast, first stage
    logic [CISG_NUM_CPU-1:0] fast_sync_r; // legacy fast, usable
    logic [CISG_NUM_CPU-1:0] norm_meta_r; // legacy normal, first stage
    logic [CISG_NUM_CPU-1:0] norm_sync_r; // legacy normal, usable
    logic [CISG_NUM_CPU-1:0] fast_nxt; // fast request next value
    logic [CISG_NUM_CPU-1:0] norm_nxt; // normal request next value
    logic [CISG_NUM_CPU-1:0] fwake_nxt; // fast wake next value
    logic [CISG_NUM_CPU-1:0] nwake_nxt; // normal wake next value
    logic [CISG_NUM_CPU*CISG_ID_W-1:0] id_nxt; // best ids next value
    logic [7:0] best_prio [CISG_NUM_CPU]; // priority of best pending per interface
    logic [3:0] cpu_count; // interfaces in use

    // interface count from the type field
    assign cpu_count = {1'b0, I_CONTROLLER_TYPE_INFO[CISG_CNT_MSB:CISG_CNT_LSB]} + 4'h1; // [R01]

    // legacy request pins pass two flops
    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            fast_meta_r <= CISG_RST_REQ;
            fast_sync_r <= CISG_RST_REQ;
            norm_meta_r <= CISG_RST_REQ;
            norm_sync_r <= CISG_RST_REQ;
        end else begin
            fast_meta_r <= I_LEGACY_FAST_INPUT;
            fast_sync_r <= fast_meta_r;
            norm_meta_r <= I_LEGACY_NORMAL_INPUT;
            norm_sync_r <= norm_meta_r;
        end
    end

    // one evaluation per interface, all in parallel
    for (genvar c = 0; c < CISG_NUM_CPU; c++) begin : g_cpu
        logic [9:0] bid; // best pending id
        logic [7:0] bprio; // its priority
        logic bg0; // best is group 0
        logic [7:0] pmask; // priority mask field
        logic [7:0] rpr; // running priority field
        logic [7:0] smsk; // group 0 grouping mask
        logic [7:0] nsmsk; // group 1 grouping mask
        logic cand; // passes mask and pending tests
        logic sig0; // group 0 may be signalled
        logic sig1; // group 1 may be signalled
        logic f; // fast line value
        logic q; // normal line value
        logic fw; // fast wake value
        logic nw; // normal wake value

        assign pmask = I_PRIORITY_MASK[c*8 +: 8];
        assign rpr = I_RUNNING_PRIORITY[c*8 +: 8];

        // highest priority pending search, lowest id wins a tie
        always_comb begin
            bid = CISG_ID_NONE; // [R13]
            bprio = CISG_PRIO_NONE;
            bg0 = 1'b0;
            for (int i = 0; i < CISG_NUM_INT; i++) begin
                if (I_INT_PENDING[i] && !I_INT_ACTIVE[i] &&
                    I_INT_TARGET[i*CISG_NUM_CPU+c] && I_INT_ENABLED[i] && // [R15]
                    (!I_GROUPING_EN || (I_INT_GROUP_ZERO[i] ? I_DIST_GROUP_ZERO_ENABLE
                                                            : I_DIST_GROUP_ONE_ENABLE)) &&
                    (I_INTERRUPT_PRIORITY_TABLE[i*8 +: 8] < bprio)) begin // [R12]
                    bid = 10'(i);
                    bprio = I_INTERRUPT_PRIORITY_TABLE[i*8 +: 8];
                    bg0 = I_INT_GROUP_ZERO[i];
                end
            end
        end

        // masks and preemption checks
        always_comb begin
            smsk = grp_mask(I_BINARY_POINT[c*3 +: 3], 1'b0); // [R09]
            nsmsk = I_COMMON_BINARY_POINT[c] ? smsk
                  : grp_mask(I_ALIASED_BINARY_POINT[c*3 +: 3], 1'b1); // [R09]
            cand = (bid != CISG_ID_NONE) && (bprio < pmask); // [R06] [R12]
            sig0 = cand && bg0 && I_DIST_GROUP_ZERO_ENABLE &&
                   (!I_ANY_ACTIVE[c] || (bprio < (rpr & smsk))); // [R07]
            sig1 = cand && !bg0 && I_DIST_GROUP_ONE_ENABLE &&
                   (!I_ANY_ACTIVE[c] || (bprio < (rpr & nsmsk))); // [R08]
        end

        // line and wake decisions; physical path only [R11]
        always_comb begin
            f = 1'b0;
            q = 1'b0;
            fw = 1'b0;
            nw = 1'b0;
            if (!I_GROUPING_EN) begin
                // ungrouped: single normal line, both enables
                q = cand && I_DIST_GROUP_ZERO_ENABLE && I_GROUP_ZERO_ENABLE[c] &&
                    (!I_ANY_ACTIVE[c] || (bprio < (rpr & smsk))); // [R10]
                nw = q;
            end else begin
                if (sig0 && I_GROUP0_AS_FAST_SELECT[c]) begin
                    fw = 1'b1; // [R02]
                    f = I_GROUP_ZERO_ENABLE[c]; // [R02]
                end else if (sig0 || sig1) begin
                    nw = 1'b1; // [R03]
                    q = sig0 ? I_GROUP_ZERO_ENABLE[c] : I_GROUP_ONE_ENABLE[c]; // [R03]
                end
                // optional legacy bypass
                if (I_BYPASS_EN &&
                    (!I_GROUP_ZERO_ENABLE[c] || !I_GROUP0_AS_FAST_SELECT[c]) &&
                    (!I_FAST_BYPASS_DISABLE_G0[c] ||
                     (!I_FAST_BYPASS_DISABLE_G1[c] && !I_GROUP0_AS_FAST_SELECT[c]))) begin
                    f = fast_sync_r[c]; // [R04]
                end
                if (I_BYPASS_EN && !I_GROUP_ONE_ENABLE[c] &&
                    (!I_GROUP_ZERO_ENABLE[c] || I_GROUP0_AS_FAST_SELECT[c]) &&
                    (!I_NORMAL_BYPASS_DISABLE_G1[c] ||
                     (!I_NORMAL_BYPASS_DISABLE_G0[c] && I_GROUP0_AS_FAST_SELECT[c]))) begin
                    q = norm_sync_r[c]; // [R05]
                end
            end
        end

        // interfaces beyond the count stay quiet
        assign fast_nxt[c] = (4'(c) < cpu_count) && f; // [R01]
        assign norm_nxt[c] = (4'(c) < cpu_count) && q; // [R01]
        assign fwake_nxt[c] = (4'(c) < cpu_count) && fw;
        assign nwake_nxt[c] = (4'(c) < cpu_count) && nw;
        assign id_nxt[c*CISG_ID_W +: CISG_ID_W] = bid;
        assign best_prio[c] = bprio;
    end

    // registered request lines, cleared by synchronous clear
    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_FAST_REQ <= CISG_RST_REQ;
            O_NORMAL_REQ <= CISG_RST_REQ;
        end else if (I_SYNC_CLR) begin
            O_FAST_REQ <= CISG_RST_REQ; // [R16]
            O_NORMAL_REQ <= CISG_RST_REQ; // [R16]
        end else begin
            O_FAST_REQ <= fast_nxt; // [R16]
            O_NORMAL_REQ <= norm_nxt; // [R16]
        end
    end

    // registered wake indications and best ids
    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_FAST_WAKE <= CISG_RST_REQ;
            O_NORMAL_WAKE <= CISG_RST_REQ;
            O_BEST_ID <= {CISG_NUM_CPU{CISG_RST_ID}};
        end else begin
            O_FAST_WAKE <= fwake_nxt; // [R16]
            O_NORMAL_WAKE <= nwake_nxt; // [R16]
            O_BEST_ID <= id_nxt; // [R13]
        end
    end

    // checks on interface 0 and the count
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_ARST_N);

    chk_fast_wake_cause: assert property ( // [R02]
        O_FAST_WAKE[0] |-> $past(I_GROUPING_EN && I_GROUP0_AS_FAST_SELECT[0]))
        else $error("fast wake without group0-as-fast");
    chk_normal_req_gate: assert property ( // [R03]
        (I_GROUPING_EN && !I_BYPASS_EN && !I_GROUP_ZERO_ENABLE[0] && !I_GROUP_ONE_ENABLE[0])
        |=> !O_NORMAL_REQ[0])
        else $error("normal request with both group enables clear");
    chk_fast_bypass: assert property ( // [R04]
        (I_GROUPING_EN && I_BYPASS_EN && !I_GROUP_ZERO_ENABLE[0] &&
         !I_FAST_BYPASS_DISABLE_G0[0] && !I_SYNC_CLR)
        |=> O_FAST_REQ[0] == $past(fast_sync_r[0]))
        else $error("fast line not following legacy input");
    chk_normal_bypass: assert property ( // [R05]
        (I_GROUPING_EN && I_BYPASS_EN && !I_GROUP_ZERO_ENABLE[0] && !I_GROUP_ONE_ENABLE[0] &&
         !I_NORMAL_BYPASS_DISABLE_G1[0] && !I_SYNC_CLR)
        |=> O_NORMAL_REQ[0] == $past(norm_sync_r[0]))
        else $error("normal line not following legacy input");
    chk_priority_mask: assert property ( // [R06]
        (best_prio[0] >= I_PRIORITY_MASK[7:0]) |=> !O_FAST_WAKE[0] && !O_NORMAL_WAKE[0])
        else $error("wake raised although priority mask blocks");
    chk_dist_enables: assert property ( // [R07]
        (I_GROUPING_EN && !I_DIST_GROUP_ZERO_ENABLE && !I_DIST_GROUP_ONE_ENABLE)
        |=> !O_FAST_WAKE[0] && !O_NORMAL_WAKE[0] && O_BEST_ID[9:0] == CISG_ID_NONE)
        else $error("signalled with distributor groups disabled");
    chk_active_preempt: assert property ( // [R08]
        (I_ANY_ACTIVE[0] && best_prio[0] >= I_RUNNING_PRIORITY[7:0])
        |=> !O_FAST_WAKE[0] && !O_NORMAL_WAKE[0])
        else $error("signalled without beating running priority");
    chk_ungrouped_fast: assert property ( // [R10]
        !I_GROUPING_EN |=> !O_FAST_REQ[0] && !O_FAST_WAKE[0])
        else $error("fast line used without grouping");
    chk_none_id: assert property ( // [R13]
        (I_INT_PENDING == '0) |=> O_BEST_ID[9:0] == CISG_ID_NONE && !O_NORMAL_WAKE[0])
        else $error("best id not spurious with nothing pending");
    chk_sync_clear: assert property ( // [R16]
        I_SYNC_CLR |=> O_FAST_REQ == '0 && O_NORMAL_REQ == '0)
        else $error("request lines high after synchronous clear");
    chk_iface_count: assert property ( // [R01]
        (I_CONTROLLER_TYPE_INFO[7:5] == 3'h0) |=> O_FAST_REQ[7:1] == '0 && O_NORMAL_REQ[7:1] == '0)
        else $error("unused interface drove a request");

    cov_fast_req: cover property (I_GROUPING_EN ##1 O_FAST_REQ[0] && O_FAST_WAKE[0]);
    cov_normal_req: cover property (O_NORMAL_REQ[0] && O_NORMAL_WAKE[0]);
    cov_bypass: cover property (I_BYPASS_EN && !I_GROUP_ZERO_ENABLE[0] ##1 O_FAST_REQ[0]);
    cov_ungrouped: cover property (!I_GROUPING_EN ##1 O_NORMAL_REQ[0]);

endmodule // cisg_top

// ---- sim/cisg_core_model.sv ----
// core-side model: counts handler entries on new request levels
`timescale 1ns/1ps
module cisg_core_model (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [7:0] i_fast_req,
    input wire logic [7:0] i_normal_req,
    output logic [15:0] o_entries
);
    logic [7:0] seen_r; // request levels of the previous edge
    // a core takes one exception per edge on which any interface's request level newly rises
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            seen_r <= 8'h00;
            o_entries <= 16'h0000;
        end else begin
            seen_r <= i_fast_req | i_normal_req;
            if (|((i_fast_req | i_normal_req) & ~seen_r)) begin
                o_entries <= o_entries + 16'h0001;
            end
        end
    end
endmodule // cisg_core_model

// ---- sim/tb_cpu_interrupt_signal_generation.sv ----
// random self-checking bench with a reference model of all interfaces
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb_cpu_interrupt_signal_generation;
    import cisg_pkg::*;
    logic clk = 0, arst_n = 0, clr = 0, grp = 1, byp = 0, dg0 = 0, dg1 = 0;
    logic [7:0] typ = 0, anya = 0, fen = 0, ge0 = 0, ge1 = 0, fb0 = 0, fb1 = 0;
    logic [7:0] nb0 = 0, nb1 = 0, cbp = 0, lf = 0, ln = 0, fr, nr, fw, nw;
    logic [31:0] pend = 0, act = 0, ena = 0, g0 = 0;
    logic [255:0] prio = 0, tgt = 0;
    logic [23:0] bp = 0, abp = 0;
    logic [63:0] pm = 0, rp = 0;
    logic [79:0] bid, eid;
    logic [7:0] lf_h[2] = '{8'h00, 8'h00}; // legacy pins, two steps back
    logic [7:0] ln_h[2] = '{8'h00, 8'h00};
    logic [1023:0] rv; // random pool for one cycle
    logic [13:0] e1;
    logic [7:0] ef, en, ew, ev;
    logic [112:0] e, exp_q[$]; // {grouped, req, wake, ids}
    logic [15:0] entries;
    int err_total = 0, n_checks = 0, seed = 16703;
    always #25 clk = ~clk;
    cisg_top cisg_top_inst (.I_CORE_CLK(clk), .I_ARST_N(arst_n), .I_SYNC_CLR(clr),
        .I_CONTROLLER_TYPE_INFO(typ), .I_GROUPING_EN(grp), .I_BYPASS_EN(byp),
        .I_DIST_GROUP_ZERO_ENABLE(dg0), .I_DIST_GROUP_ONE_ENABLE(dg1), .I_INT_PENDING(pend),
        .I_INT_ACTIVE(act), .I_INT_ENABLED(ena), .I_INT_GROUP_ZERO(g0),
        .I_INTERRUPT_PRIORITY_TABLE(prio), .I_INT_TARGET(tgt), .I_ANY_ACTIVE(anya),
        .I_GROUP0_AS_FAST_SELECT(fen), .I_GROUP_ZERO_ENABLE(ge0), .I_GROUP_ONE_ENABLE(ge1),
        .I_FAST_BYPASS_DISABLE_G0(fb0), .I_FAST_BYPASS_DISABLE_G1(fb1),
        .I_NORMAL_BYPASS_DISABLE_G0(nb0), .I_NORMAL_BYPASS_DISABLE_G1(nb1),
        .I_COMMON_BINARY_POINT(cbp), .I_BINARY_POINT(bp), .I_ALIASED_BINARY_POINT(abp),
        .I_PRIORITY_MASK(pm), .I_RUNNING_PRIORITY(rp), .I_LEGACY_FAST_INPUT(lf),
        .I_LEGACY_NORMAL_INPUT(ln), .O_FAST_REQ(fr), .O_NORMAL_REQ(nr), .O_FAST_WAKE(fw),
        .O_NORMAL_WAKE(nw), .O_BEST_ID(bid));
    cisg_core_model cisg_core_model_inst (.i_clk(clk), .i_arst_n(arst_n),
        .i_fast_req(fr), .i_normal_req(nr), .o_entries(entries));
    // grouping mask: keep top bits, ns steps down, saturate at minimum
    function automatic logic [7:0] gmask(int n, bit ns);
        n = n - int'(ns);
        if (n < CISG_MIN_BP) n = CISG_MIN_BP;
        return 8'hff << (n + 1);
    endfunction
    // expected {fast req, normal req, fast wake, normal wake, id} of interface c
    function automatic logic [13:0] ref_if(int c);
        logic [9:0] id;
        logic [7:0] bpr, m;
        logic g, sig, f_r, n_r, f_w, n_w;
        id = CISG_ID_NONE;
        bpr = CISG_PRIO_NONE;
        {f_r, n_r, f_w, n_w} = 4'h0;
        for (int i = 0; i < 32; i++) begin
            if (pend[i] && !act[i] && tgt[i*8+c] && ena[i] && (!grp || (g0[i] ? dg0 : dg1)) &&
                prio[i*8+:8] < bpr) begin
                id = 10'(i);
                bpr = prio[i*8+:8];
            end
        end
        g = g0[id[4:0]];
        m = gmask(int'(bp[c*3+:3]), 1'b0);
        if (!g && !cbp[c]) m = gmask(int'(abp[c*3+:3]), 1'b1);
        sig = id != CISG_ID_NONE && bpr < pm[c*8+:8] && (g ? dg0 : dg1) &&
            (!anya[c] || bpr < (rp[c*8+:8] & m));
        if (!grp) begin
            n_r = sig && ge0[c];
            n_w = n_r;
        end else begin
            if (sig && g && fen[c]) begin
                f_w = 1'b1;
                f_r = ge0[c];
            end else if (sig) begin
                n_w = 1'b1;
                n_r = g ? ge0[c] : ge1[c];
            end
            if (byp && (!ge0[c] || !fen[c]) && (!fb0[c] || (!fb1[c] && !fen[c])))
                f_r = lf_h[1][c];
            if (byp && !ge1[c] && (!ge0[c] || fen[c]) && (!nb1[c] || (!nb0[c] && fen[c])))
                n_r = ln_h[1][c];
        end
        if (c > int'(typ[7:5])) {f_r, n_r, f_w, n_w} = 4'h0;
        if (clr) {f_r, n_r} = 2'b00;
        return {f_r, n_r, f_w, n_w, id};
    endfunction
    // verdict and end of run
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // driver: random inputs on the falling edge, expectation queued
    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        for (int k = 0; k < 1500; k++) begin
            if (k > 0) @(negedge clk);
            lf_h[1] = lf_h[0];
            lf_h[0] = lf;
            ln_h[1] = ln_h[0];
            ln_h[0] = ln;
            for (int j = 0; j < 32; j++) rv[j*32+:32] = $random(seed);
            {prio, tgt, pm, rp, bp, abp, anya, fen, ge0, ge1, fb0, fb1, nb0, nb1, cbp, lf, ln,
                typ} = rv[783:0];
            pend = rv[815:784] & rv[847:816];
            act = rv[879:848] & rv[911:880];
            ena = ~(rv[943:912] & rv[975:944]);
            grp = |rv[977:976];
            byp = rv[978];
            dg0 = |rv[980:979];
            dg1 = |rv[982:981];
            clr = &rv[985:983];
            g0 = grp ? rv[1017:986] : 32'hffffffff; // ungrouped: one group only
            for (int c = 0; c < 8; c++) begin
                e1 = ref_if(c);
                {ef[c], en[c], ew[c], ev[c]} = e1[13:10];
                eid[c*10+:10] = e1[9:0];
            end
            exp_q.push_back({grp, ef, en, ew, ev, eid});
        end
        @(posedge clk);
        #2;
        `CHK(entries != 16'h0000, 1'b1)
        end_of_test();
    end
    // monitor: one registered result per edge, oldest note first
    always @(posedge clk) begin
        if (exp_q.size() > 0) begin
            #1;
            e = exp_q.pop_front();
            `CHK({fr, nr}, e[111:96])
            `CHK({fw, nw}, e[95:80])
            `CHK(bid, e[79:0])
        end
    end
    // watchdog against a hung run
    initial begin
        #200000;
        err_total++;
        end_of_test();
    end
endmodule // tb_cpu_interrupt_signal_generation
